/* rtl/mac_tx_pkg.sv */
// Shared constants and types for the transmit frame assembly block
package mac_tx_pkg;
  // Register byte addresses
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [7:0] MAXLEN_ADDR = 8'h04;
  localparam logic [7:0] STAT_ADDR = 8'h08;
  // Configuration register fields
  localparam int CFG_FCS_BIT = 0;
  localparam int CFG_HUGE_BIT = 1;
  localparam int CFG_PAD_LSB = 2;
  localparam int CFG_PAD_W = 3;
  localparam logic [4:0] CFG_RST = 5'h01;
  localparam logic [15:0] MAXLEN_RST = 16'h05EE;
  // Status register fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_ABORT_BIT = 1;
  localparam int STAT_CRCERR_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_FCS_BIT = 4;
  localparam int STAT_CNT_LSB = 16;
  // Per-packet control byte fields; bits 7 to 4 unused
  localparam int CTL_OVERRIDE_BIT = 0;
  localparam int CTL_FCS_BIT = 1;
  localparam int CTL_PAD_BIT = 2;
  localparam int CTL_HUGE_BIT = 3;
  // Framing constants
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [2:0] PRE_LAST = 3'h7;
  localparam logic [15:0] PAD_SHORT = 16'h003C;
  localparam logic [15:0] PAD_LONG = 16'h0040;
  localparam logic [1:0] FCS_LAST = 2'h3;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  // Buffer shape
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 16;
  // Engine states
  typedef enum logic [2:0] {ST_CTRL, ST_PRE, ST_DATA, ST_PAD, ST_FCS, ST_DRAIN, ST_DONE} tx_state_e;
endpackage

/* rtl/mac_tx_frame_assembly.sv */
// Transmit frame assembly: byte buffer, framing engine and register port
//
// Functional notes
// - Device adds preamble and SFD itself
// - Pad and FCS only when configured
// - One control byte leads each packet
// - Pad flag zero-pads short frames to 60
// - FCS flag appends a computed CRC
// - No FCS: check last four bytes instead
// - Global huge off: abort over-length frames
// - Global FCS off: check, report bad CRC
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps

module mac_tx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wptr_reg; // Write index
  logic [AW-1:0] rptr_reg; // Read index
  logic [AW:0] cnt_reg; // Words held
  logic [AW:0] cnt_next;
  logic ready_reg; // Registered room flag
  logic push;
  logic pop;

  assign push = in_valid && ready_reg;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rptr_reg];
  assign in_ready = ready_reg;

  // Occupancy follows both sides at once
  always_comb
  begin
    cnt_next = cnt_reg;
    if (push && !pop)
    begin
      cnt_next = cnt_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Pointers and count; ready is registered so the filler sees a flop
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop)
      begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      ready_reg <= (cnt_next != FULL);
    end
  end

  // Data array has no reset, only written on a push
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wptr_reg] <= in_data;
    end
  end
endmodule

module mac_tx_frame_assembly (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Packet bytes from buffer memory: control byte first
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_data,
  input wire logic pkt_last,
  output logic pkt_ready,
  // Frame bytes toward the line
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  // Per-packet outcome
  output logic tx_done,
  output logic tx_abort,
  output logic tx_crc_err
);
  import mac_tx_pkg::*;

  tx_state_e state_reg, state_next; // Engine state
  logic [4:0] mac_tx_config; // Global configuration bits
  logic [15:0] max_frame_length; // Length limit without huge mode
  logic global_fcs_append_en;
  logic global_huge_frame_en;
  logic [CFG_PAD_W-1:0] global_pad_config;
  logic fifo_valid; // Buffer head present
  logic [8:0] fifo_word; // Last flag and byte
  logic pop; // Take buffer head
  logic adv; // Output slot free this cycle
  logic emit; // Load a byte into the output slot
  logic [7:0] emit_data;
  logic emit_last;
  logic abort_now; // Over-length packet detected
  logic cnt_inc; // Counted byte leaves
  logic [2:0] pre_cnt_reg; // Preamble position
  logic [15:0] byte_cnt_reg; // Data and pad bytes sent
  logic [15:0] cnt1; // Count including this byte
  logic [31:0] crc_reg; // Running CRC, reflected
  logic [31:0] crc_inv;
  logic [1:0] fcs_idx_reg; // FCS byte position
  logic fcs_en_reg; // Effective per-packet settings
  logic pad_en_reg;
  logic huge_reg;
  logic [15:0] pad_min_reg;
  logic tx_valid_reg, tx_last_reg, tx_done_reg, tx_abort_reg;
  logic [7:0] tx_data_reg;
  logic stat_done_reg, stat_abort_reg, stat_crc_err_reg, stat_fcs_reg;
  logic [15:0] stat_cnt_reg; // Bytes of last finished packet
  logic [31:0] reg_rdata_reg;

  assign global_fcs_append_en = mac_tx_config[CFG_FCS_BIT];
  assign global_huge_frame_en = mac_tx_config[CFG_HUGE_BIT];
  assign global_pad_config = mac_tx_config[CFG_PAD_LSB +: CFG_PAD_W];
  assign adv = !tx_valid_reg || tx_ready;
  assign cnt1 = byte_cnt_reg + 16'h0001;
  assign crc_inv = ~crc_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;
  assign tx_last = tx_last_reg;
  assign tx_done = tx_done_reg;
  assign tx_abort = tx_abort_reg;
  assign tx_crc_err = stat_crc_err_reg;
  assign reg_rdata = reg_rdata_reg;

  // One byte step of the reflected CRC-32
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Sixteen-word buffer between the memory reader and the engine
  mac_tx_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(pkt_valid),
    .in_data({pkt_last, pkt_data}),
    .in_ready(pkt_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_word),
    .out_ready(pop)
  );

  // Engine decisions; every emitted byte waits for a free output slot
  always_comb
  begin
    state_next = state_reg;
    pop = 1'b0;
    emit = 1'b0;
    emit_data = 8'h00;
    emit_last = 1'b0;
    abort_now = 1'b0;
    cnt_inc = 1'b0;
    case (state_reg)
      ST_CTRL:
      begin
        // Control byte is consumed, never sent
        if (fifo_valid)
        begin
          pop = 1'b1;
          state_next = ST_PRE;
        end
      end
      ST_PRE:
      begin
        // Preamble and SFD come from the engine, not the buffer
        if (adv)
        begin
          emit = 1'b1;
          emit_data = (pre_cnt_reg == PRE_LAST) ? SFD_BYTE : PRE_BYTE;
          if (pre_cnt_reg == PRE_LAST)
          begin
            state_next = ST_DATA;
          end
        end
      end
      ST_DATA:
      begin
        if (adv && fifo_valid)
        begin
          pop = 1'b1;
          if (!huge_reg && byte_cnt_reg >= max_frame_length)
          begin
            // Over the limit: stop sending and discard the rest
            abort_now = 1'b1;
            state_next = fifo_word[8] ? ST_DONE : ST_DRAIN;
          end
          else
          begin
            emit = 1'b1;
            emit_data = fifo_word[7:0];
            cnt_inc = 1'b1;
            if (fifo_word[8])
            begin
              if (pad_en_reg && cnt1 < pad_min_reg)
              begin
                state_next = ST_PAD;
              end
              else if (fcs_en_reg)
              begin
                state_next = ST_FCS;
              end
              else
              begin
                emit_last = 1'b1;
                state_next = ST_DONE;
              end
            end
          end
        end
      end
      ST_PAD:
      begin
        // Zero bytes until the minimum length is met
        if (adv)
        begin
          emit = 1'b1;
          cnt_inc = 1'b1;
          if (cnt1 >= pad_min_reg)
          begin
            if (fcs_en_reg)
            begin
              state_next = ST_FCS;
            end
            else
            begin
              emit_last = 1'b1;
              state_next = ST_DONE;
            end
          end
        end
      end
      ST_FCS:
      begin
        // Complemented CRC, low byte first
        if (adv)
        begin
          emit = 1'b1;
          emit_data = 8'(crc_inv >> {fcs_idx_reg, 3'b000});
          if (fcs_idx_reg == FCS_LAST)
          begin
            emit_last = 1'b1;
            state_next = ST_DONE;
          end
        end
      end
      ST_DRAIN:
      begin
        // Drop the remainder of an aborted packet
        if (fifo_valid)
        begin
          pop = 1'b1;
          if (fifo_word[8])
          begin
            state_next = ST_DONE;
          end
        end
      end
      ST_DONE:
      begin
        state_next = ST_CTRL;
      end
      default:
      begin
        state_next = ST_CTRL;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_reg <= ST_CTRL;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Per-packet settings latched from the control byte
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      fcs_en_reg <= 1'b0;
      pad_en_reg <= 1'b0;
      huge_reg <= 1'b0;
      pad_min_reg <= PAD_SHORT;
    end
    else if (state_reg == ST_CTRL && pop)
    begin
      if (fifo_word[CTL_OVERRIDE_BIT])
      begin
        // Override: per-packet bits win over the configuration
        fcs_en_reg <= fifo_word[CTL_FCS_BIT];
        pad_en_reg <= fifo_word[CTL_PAD_BIT];
        huge_reg <= fifo_word[CTL_HUGE_BIT];
        pad_min_reg <= PAD_SHORT;
      end
      else
      begin
        // Bits 3..1 ignored; odd pad codes pad, bit 1 of the code picks 64
        fcs_en_reg <= global_fcs_append_en;
        pad_en_reg <= global_pad_config[0];
        huge_reg <= global_huge_frame_en;
        pad_min_reg <= global_pad_config[1] ? PAD_LONG : PAD_SHORT;
      end
    end
  end

  // Position counters and CRC accumulation over data and pad
  always_ff @(posedge core_clk)
  begin
    if (srst || state_reg == ST_CTRL)
    begin
      pre_cnt_reg <= '0;
      byte_cnt_reg <= '0;
      fcs_idx_reg <= '0;
      crc_reg <= CRC_INIT;
    end
    else
    begin
      if (state_reg == ST_PRE && adv)
      begin
        pre_cnt_reg <= pre_cnt_reg + 3'h1;
      end
      if (cnt_inc)
      begin
        byte_cnt_reg <= cnt1;
        crc_reg <= crc_byte(crc_reg, emit_data);
      end
      if (state_reg == ST_FCS && adv)
      begin
        fcs_idx_reg <= fcs_idx_reg + 2'h1;
      end
    end
  end

  // Output slot: holds a byte until the line takes it
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      tx_last_reg <= 1'b0;
    end
    else if (emit)
    begin
      tx_valid_reg <= 1'b1;
      tx_data_reg <= emit_data;
      tx_last_reg <= emit_last;
    end
    else if (tx_ready)
    begin
      tx_valid_reg <= 1'b0;
      tx_last_reg <= 1'b0;
    end
  end

  // Packet outcome: pulses and last-packet status
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      tx_done_reg <= 1'b0;
      tx_abort_reg <= 1'b0;
      stat_done_reg <= 1'b0;
      stat_abort_reg <= 1'b0;
      stat_crc_err_reg <= 1'b0;
      stat_fcs_reg <= 1'b0;
      stat_cnt_reg <= '0;
    end
    else
    begin
      tx_done_reg <= (state_reg == ST_DONE);
      tx_abort_reg <= abort_now;
      if (state_reg == ST_CTRL && pop)
      begin
        stat_done_reg <= 1'b0;
        stat_abort_reg <= 1'b0;
      end
      else if (abort_now)
      begin
        stat_abort_reg <= 1'b1;
      end
      if (state_reg == ST_DONE)
      begin
        // Without appended FCS the trailing four bytes must leave the residue
        stat_done_reg <= 1'b1;
        stat_crc_err_reg <= !fcs_en_reg && !stat_abort_reg && (crc_reg != CRC_RESIDUE);
        stat_fcs_reg <= fcs_en_reg;
        stat_cnt_reg <= byte_cnt_reg;
      end
    end
  end

  // Register writes; the host should set these before queueing packets
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      mac_tx_config <= CFG_RST;
      max_frame_length <= MAXLEN_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == CFG_ADDR)
      begin
        mac_tx_config <= reg_wdata[4:0];
      end
      if (reg_addr == MAXLEN_ADDR)
      begin
        max_frame_length <= reg_wdata[15:0];
      end
    end
  end

  // Register reads, answered one cycle later; unmapped reads give zero
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      reg_rdata_reg <= '0;
    end
    else if (reg_rd)
    begin
      reg_rdata_reg <= '0;
      case (reg_addr)
        CFG_ADDR: reg_rdata_reg[4:0] <= mac_tx_config;
        MAXLEN_ADDR: reg_rdata_reg[15:0] <= max_frame_length;
        STAT_ADDR:
        begin
          reg_rdata_reg[STAT_DONE_BIT] <= stat_done_reg;
          reg_rdata_reg[STAT_ABORT_BIT] <= stat_abort_reg;
          reg_rdata_reg[STAT_CRCERR_BIT] <= stat_crc_err_reg;
          reg_rdata_reg[STAT_BUSY_BIT] <= (state_reg != ST_CTRL);
          reg_rdata_reg[STAT_FCS_BIT] <= stat_fcs_reg;
          reg_rdata_reg[STAT_CNT_LSB +: 16] <= stat_cnt_reg;
        end
        default: reg_rdata_reg <= '0;
      endcase
    end
  end

  // Checks beside the engine
  a_sfd_after_pre: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_PRE && adv && pre_cnt_reg == PRE_LAST) |=> (tx_valid_reg && tx_data_reg == SFD_BYTE))
    else $error("SFD missing after preamble");
  a_ctrl_not_sent: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_CTRL && pop) |=> (state_reg == ST_PRE && pre_cnt_reg == 3'h0 && $stable(tx_data_reg)))
    else $error("Control byte was not consumed silently");
  a_pad_zero: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_PAD && adv) |-> (pad_en_reg && byte_cnt_reg < pad_min_reg) ##1 (tx_data_reg == 8'h00))
    else $error("Padding byte wrong or beyond minimum");
  a_fcs_only_en: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_FCS) |-> fcs_en_reg)
    else $error("FCS sent while disabled");
  a_fcs_first_byte: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_FCS && adv && fcs_idx_reg == 2'h0) |=> (tx_data_reg == ~($past(crc_reg[7:0]))))
    else $error("First FCS byte wrong");
  a_fcs_ends_frame: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_FCS && adv && fcs_idx_reg == FCS_LAST) |=> (tx_last_reg ##1 (state_reg == ST_CTRL)))
    else $error("Frame did not end after FCS");
  a_crc_check: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_DONE && !fcs_en_reg && !stat_abort_reg)
      |=> (stat_crc_err_reg == ($past(crc_reg) != CRC_RESIDUE)))
    else $error("CRC check result wrong");
  a_no_override: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_CTRL && pop && !fifo_word[CTL_OVERRIDE_BIT])
      |=> (fcs_en_reg == $past(global_fcs_append_en) && huge_reg == $past(global_huge_frame_en)))
    else $error("Override clear but control bits used");
  a_override_on: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_CTRL && pop && fifo_word[CTL_OVERRIDE_BIT])
      |=> (fcs_en_reg == $past(fifo_word[CTL_FCS_BIT]) && pad_en_reg == $past(fifo_word[CTL_PAD_BIT])))
    else $error("Override set but control bits not used");
  a_giant_abort: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_DATA && pop && !huge_reg && byte_cnt_reg >= max_frame_length)
      |=> (tx_abort_reg && stat_abort_reg) ##1 !tx_abort_reg)
    else $error("Over-length packet not aborted");
  c_override_pkt: cover property (@(posedge core_clk) disable iff (srst)
    state_reg == ST_CTRL && pop && fifo_word[CTL_OVERRIDE_BIT]);
  c_padding: cover property (@(posedge core_clk) disable iff (srst)
    state_reg == ST_PAD ##[1:80] state_reg == ST_FCS);
  c_abort: cover property (@(posedge core_clk) disable iff (srst) tx_abort_reg);
  c_crc_bad: cover property (@(posedge core_clk) disable iff (srst) $rose(stat_crc_err_reg));
endmodule

/* testbench/host_frame_writer.sv */
// Behavioural host that writes one packet, control byte first, into the block
`timescale 1ns/100ps
module host_frame_writer (
  // Clock
  input wire logic core_clk,
  // Packet byte stream toward the block
  output logic pkt_valid,
  output logic [7:0] pkt_data,
  output logic pkt_last,
  input wire logic pkt_ready
);
  // Idle at time zero
  initial
  begin
    pkt_valid = 1'b0;
    pkt_data = 8'h00;
    pkt_last = 1'b0;
  end
  // Control byte, then the fields; slow leaves a gap after every byte
  task automatic send(input logic [7:0] ctl, input logic [7:0] q[$], input bit slow);
    int i;
    @(posedge core_clk);
    for (i = 0; i <= q.size(); i++)
    begin
      pkt_valid <= 1'b1;
      pkt_data <= (i == 0) ? ctl : q[i-1];
      pkt_last <= (i == q.size());
      do @(posedge core_clk); while (!pkt_ready);
      if (slow)
      begin
        // Released data is inverted so a stale byte cannot pass
        pkt_valid <= 1'b0;
        pkt_last <= 1'b0;
        pkt_data <= ~pkt_data;
        @(posedge core_clk);
      end
    end
    // A slow send has already released and inverted the last byte
    if (!slow)
    begin
      pkt_valid <= 1'b0;
      pkt_last <= 1'b0;
      pkt_data <= ~pkt_data;
    end
  endtask
endmodule

/* testbench/test_mac_tx_frame_assembly.sv */
// Self-checking bench for the transmit frame assembly block
`timescale 1ns/100ps
module test_mac_tx_frame_assembly;
  import mac_tx_pkg::*;
  // Clock, reset and register port
  logic core_clk, srst, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  // Packet and frame streams
  logic pkt_valid, pkt_last, pkt_ready, tx_valid, tx_last;
  logic tx_ready = 1'b1;
  logic [7:0] pkt_data, tx_data;
  logic tx_done, tx_abort, tx_crc_err;
  // Bookkeeping of the line side
  int n_mismatch = 0;
  int checks_done = 0;
  int done_cnt = 0;
  int last_at;
  bit aborted, stall;
  logic [1:0] cyc = 2'h0;
  logic [7:0] dq[$], got[$];

  mac_tx_frame_assembly DUT (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .tx_done(tx_done), .tx_abort(tx_abort), .tx_crc_err(tx_crc_err));
  host_frame_writer host (.core_clk(core_clk), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
    .pkt_last(pkt_last), .pkt_ready(pkt_ready));

  // 125 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Line side: collects bytes, stalls one cycle in four when asked
  always @(posedge core_clk)
  begin
    cyc <= cyc + 2'h1;
    tx_ready <= !stall || cyc != 2'h0;
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    if (tx_valid && tx_ready && tx_last)
      last_at = got.size();
    if (tx_abort)
      aborted = 1'b1;
    if (tx_done)
      done_cnt++;
  end

  // Compare and count
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Register read; data appears the cycle after the strobe and holds until the next read
  task automatic rd(logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    v = reg_rdata;
  endtask

  // Reflected CRC over a slice of a byte queue, complemented as sent
  function automatic logic [31:0] fcs_of(logic [7:0] q[$], int from, int to);
    logic [31:0] c;
    int i, k;
    c = CRC_INIT;
    for (i = from; i < to; i++)
    begin
      c = c ^ {24'h000000, q[i]};
      for (k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction

  // Payload of n bytes; tail 1 adds a good CRC, tail 2 a corrupted one
  task automatic fill(int n, int tail);
    logic [31:0] f;
    int i;
    dq.delete();
    for (i = 0; i < n; i++)
      dq.push_back(8'(i * 37 + 5));
    f = fcs_of(dq, 0, n) ^ ((tail == 2) ? 32'h00000001 : 32'h00000000);
    for (i = 0; i < 4 && tail != 0; i++)
      dq.push_back(f[8*i +: 8]);
  endtask

  // Send dq and judge the frame; lim is the length past which abort is due
  task automatic xfer(logic [7:0] ctl, int pad_min, bit fcs, int lim, int err, bit slow);
    logic [7:0] exp[$];
    logic [31:0] v;
    int i, n, base;
    bit ab;
    ab = lim < dq.size();
    n = ab ? lim : dq.size();
    for (i = 0; i < 8; i++)
      exp.push_back(i < 7 ? PRE_BYTE : SFD_BYTE);
    for (i = 0; i < n; i++)
      exp.push_back(dq[i]);
    while (!ab && exp.size() < pad_min + 8)
      exp.push_back(8'h00);
    v = fcs_of(exp, 8, exp.size());
    for (i = 0; i < 4 && fcs && !ab; i++)
      exp.push_back(v[8*i +: 8]);
    got.delete();
    last_at = -1;
    aborted = 1'b0;
    base = done_cnt;
    stall = slow;
    host.send(ctl, dq, slow);
    for (i = 0; i < 3000 && done_cnt == base; i++)
      @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    check("done pulses", done_cnt - base, 1);
    check("frame length", got.size(), exp.size());
    for (i = 0; i < exp.size() && i < got.size(); i++)
      check("frame byte", got[i], exp[i]);
    check("last flag position", last_at, ab ? -1 : exp.size());
    check("abort pulse", aborted, ab);
    if (err >= 0)
      check("crc error flag", tx_crc_err, err);
    rd(STAT_ADDR, v);
    check("status aborted", v[STAT_ABORT_BIT], ab);
    check("status done", v[STAT_DONE_BIT], 1'b1);
    if (!ab)
      check("status fcs", v[STAT_FCS_BIT], fcs);
    if (!ab)
      check("status count", v[31:16], exp.size() - 8 - (fcs ? 4 : 0));
  endtask

  // Reset values, read-only status, unmapped address
  task automatic t_regs();
    logic [31:0] v;
    rd(CFG_ADDR, v);
    check("config reset", v, 32'(CFG_RST));
    rd(MAXLEN_ADDR, v);
    check("max length reset", v, 32'(MAXLEN_RST));
    wr(STAT_ADDR, 32'hFFFFFFFF);
    rd(STAT_ADDR, v);
    check("status after write", v, 32'h00000000);
    rd(8'h0C, v);
    check("unmapped read", v, 32'h00000000);
  endtask

  // Scenario bodies; each calls xfer which judges the frame
  task automatic t_frames();
    fill(14, 0);
    xfer(8'h00, 0, 1'b1, 9999, 0, 1'b0);
    fill(10, 0);
    xfer(8'hF7, 60, 1'b1, 9999, 0, 1'b1);
    fill(10, 1);
    xfer(8'h01, 0, 1'b0, 9999, 0, 1'b0);
    fill(10, 2);
    xfer(8'h01, 0, 1'b0, 9999, 1, 1'b1);
    wr(CFG_ADDR, 32'h00000000);
    fill(10, 2);
    xfer(8'h0E, 0, 1'b0, 9999, 1, 1'b0);
    fill(10, 1);
    xfer(8'h0E, 0, 1'b0, 9999, 0, 1'b0);
    wr(CFG_ADDR, 32'h0000000D);
    fill(10, 0);
    xfer(8'h00, 64, 1'b1, 9999, 0, 1'b0);
    wr(CFG_ADDR, 32'h00000005);
    fill(10, 0);
    xfer(8'h00, 60, 1'b1, 9999, 0, 1'b0);
  endtask

  // Length limit, boundary, per-packet huge override
  task automatic t_length();
    wr(MAXLEN_ADDR, 32'h00000010);
    wr(CFG_ADDR, 32'h00000001);
    fill(16, 0);
    xfer(8'h00, 0, 1'b1, 9999, 0, 1'b0);
    fill(20, 0);
    xfer(8'h00, 0, 1'b1, 16, -1, 1'b0);
    xfer(8'h03, 0, 1'b1, 16, -1, 1'b1);
    xfer(8'h0B, 0, 1'b1, 9999, 0, 1'b0);
    wr(CFG_ADDR, 32'h00000003);
    xfer(8'h00, 0, 1'b1, 9999, 0, 1'b0);
  endtask

  // Main sequence
  initial
  begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    stall = 1'b0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    t_regs();
    t_frames();
    t_length();
    wrap_up();
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end
endmodule
